// ---- verilog/perf_mon_pkg.sv ----
// Shared constants, types and helpers for the performance event counting block
`default_nettype none

package perf_mon_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NUM_GEN = 2;
	localparam int NUM_FIXED = 3;
	localparam int CTR_W = 40;
	localparam int MSR_W = 64;
	localparam int IDX_W = 4;
	localparam int UMASK_W = 8;
	localparam int EVSEL_W = 32;
	localparam int FIXED_FIELD_W = 4;
	localparam int FIXED_CTRL_W = NUM_FIXED * FIXED_FIELD_W;

	// ****************************************************************
	// Register indices
	// ****************************************************************
	localparam logic [IDX_W-1:0] REG_EVSEL0 = 4'h0;
	localparam logic [IDX_W-1:0] REG_GEN_CTR0 = 4'h2;
	localparam logic [IDX_W-1:0] REG_FIXED_CTRL = 4'h4;
	localparam logic [IDX_W-1:0] REG_FIXED_CTR0 = 4'h5;

	// ****************************************************************
	// Event select fields
	// ****************************************************************
	localparam int UMASK_LSB = 8;
	localparam int EVSEL_USR_BIT = 16;
	localparam int EVSEL_OS_BIT = 17;
	localparam int EVSEL_INT_BIT = 20;
	localparam int EVSEL_EN_BIT = 22;

	// Positions below are relative to the unit mask's bit 0 (bit 8 of the register)
	localparam int CORE_SCOPE_LSB = 14 - UMASK_LSB;
	localparam int AGENT_ALL_BIT = 13 - UMASK_LSB;
	localparam int PREFETCH_LSB = 12 - UMASK_LSB;
	localparam int STATE_LSB = 8 - UMASK_LSB;
	localparam int SNRESP_SNOOP_HIT_MODIFIED_BIT = 11 - UMASK_LSB;
	localparam int SNRESP_RSVD_BIT = 10 - UMASK_LSB;
	localparam int SNRESP_HIT_BIT = 9 - UMASK_LSB;
	localparam int SNRESP_CLEAN_BIT = 8 - UMASK_LSB;
	localparam int SNTYPE_INV_BIT = 9 - UMASK_LSB;
	localparam int SNTYPE_SHR_BIT = 8 - UMASK_LSB;

	localparam logic [1:0] SCOPE_ALL_CORES = 2'h3;
	localparam logic [1:0] SCOPE_THIS_CORE = 2'h1;
	localparam logic [1:0] PREFETCH_ALL = 2'h3;
	localparam logic [1:0] PREFETCH_ONLY = 2'h1;
	localparam logic [1:0] PREFETCH_EXCLUDE = 2'h0;

	// ****************************************************************
	// Fixed counter control fields
	// ****************************************************************
	localparam int FIXED_RING0_BIT = 0;
	localparam int FIXED_INT_BIT = 3;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [EVSEL_W-1:0] EVSEL_RST = 32'h0000_0000;
	localparam logic [FIXED_CTRL_W-1:0] FIXED_CTRL_RST = 12'h000;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {UPPER_NONE, UPPER_AGENT, UPPER_PREFETCH} upper_qual_e;
	typedef enum logic [1:0] {LOW_NONE, LOW_LINE_STATE, LOW_SNOOP_RESP, LOW_SNOOP_TYPE} low_qual_e;

	typedef struct packed {
		logic core_scoped;
		upper_qual_e upper;
		low_qual_e low;
	} event_class_s;

	typedef struct packed {
		logic valid;
		logic this_core;
		logic this_agent;
		logic hw_prefetch;
		logic [3:0] line_state;
		logic snoop_hit_modified;
		logic snoop_hit;
		logic snoop_clean;
		logic snoop_to_invalid;
		logic snoop_to_shared;
	} event_occ_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [IDX_W-1:0] idx;
		logic [MSR_W-1:0] wdata;
	} msr_req_s;

	typedef struct packed {
		logic ack;
		logic fault;
		logic [MSR_W-1:0] rdata;
	} msr_rsp_s;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// en[0] counts at ring 0, en[1] at rings above 0
	function automatic logic priv_match(input logic ring0, input logic [1:0] en);
		return ring0 ? en[0] : en[1];
	endfunction

	// Returns {wrap, next}; wrap is set when all ones roll to zero
	function automatic logic [CTR_W:0] ctr_step(input logic [CTR_W-1:0] cnt);
		logic [CTR_W:0] sum;
		sum = {1'b0, cnt} + {{CTR_W{1'b0}}, 1'b1};
		return sum;
	endfunction

endpackage

`default_nettype wire

// ---- verilog/umask_qualify.sv ----
// Unit mask qualifier decode for one general counter
`default_nettype none
`timescale 1ns/1ps

module umask_qualify
	import perf_mon_pkg::*;
(
	input wire logic [UMASK_W-1:0] i_umask,
	input wire event_class_s i_class,
	input wire event_occ_s i_occ,
	output logic o_hit
);

	logic core_ok;
	logic upper_ok;
	logic low_ok;
	logic [1:0] scope_code;
	logic [1:0] pref_code;

	assign scope_code = i_umask[CORE_SCOPE_LSB +: 2];
	assign pref_code = i_umask[PREFETCH_LSB +: 2];

	// ****************************************************************
	// Core scope
	// ****************************************************************
	always_comb
	begin
		core_ok = 1'b1;
		if (i_class.core_scoped)
		begin
			if (scope_code == SCOPE_ALL_CORES)
				core_ok = 1'b1;
			else if (scope_code == SCOPE_THIS_CORE)
				core_ok = i_occ.this_core;
			else
				core_ok = 1'b0;
		end
	end

	// ****************************************************************
	// Agent or prefetch, never both
	// ****************************************************************
	always_comb
	begin
		upper_ok = 1'b1;
		unique case (i_class.upper)
			UPPER_NONE: upper_ok = 1'b1;
			UPPER_AGENT: upper_ok = i_umask[AGENT_ALL_BIT] | i_occ.this_agent;
			UPPER_PREFETCH:
			begin
				if (pref_code == PREFETCH_ALL)
					upper_ok = 1'b1;
				else if (pref_code == PREFETCH_ONLY)
					upper_ok = i_occ.hw_prefetch;
				else if (pref_code == PREFETCH_EXCLUDE)
					upper_ok = ~i_occ.hw_prefetch;
				else
					upper_ok = 1'b0;
			end
			default: upper_ok = 1'b0;
		endcase
	end

	// ****************************************************************
	// Low nibble: one qualifier kind per event
	// ****************************************************************
	always_comb
	begin
		low_ok = 1'b1;
		unique case (i_class.low)
			LOW_NONE: low_ok = 1'b1;
			// No state bit set means nothing matches
			LOW_LINE_STATE: low_ok = |(i_umask[STATE_LSB +: 4] & i_occ.line_state);
			LOW_SNOOP_RESP:
				low_ok = ~i_umask[SNRESP_RSVD_BIT] &
					((i_umask[SNRESP_SNOOP_HIT_MODIFIED_BIT] & i_occ.snoop_hit_modified) |
					(i_umask[SNRESP_HIT_BIT] & i_occ.snoop_hit) |
					(i_umask[SNRESP_CLEAN_BIT] & i_occ.snoop_clean));
			LOW_SNOOP_TYPE:
				low_ok = (i_umask[SNTYPE_INV_BIT] & i_occ.snoop_to_invalid) |
					(i_umask[SNTYPE_SHR_BIT] & i_occ.snoop_to_shared);
		endcase
	end

	assign o_hit = i_occ.valid & core_ok & upper_ok & low_ok;

endmodule // umask_qualify

`default_nettype wire

// ---- verilog/perf_event_qualify_fixed_counters.sv ----
// Qualified general counters and fixed-function counters with register port
`default_nettype none
`timescale 1ns/1ps

module perf_event_qualify_fixed_counters
	import perf_mon_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	input wire msr_req_s i_msr_req,
	output msr_rsp_s o_msr_rsp,
	input wire event_class_s i_gen_class0,
	input wire event_class_s i_gen_class1,
	input wire event_occ_s i_gen_occ0,
	input wire event_occ_s i_gen_occ1,
	input wire logic i_ring0,
	input wire logic [NUM_FIXED-1:0] i_fixed_event,
	output logic o_overflow_irq
);

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [EVSEL_W-1:0] evsel_q [NUM_GEN];
	logic [CTR_W-1:0] gen_ctr_q [NUM_GEN];
	logic [FIXED_CTRL_W-1:0] fixed_ctrl_q;
	logic [CTR_W-1:0] fixed_ctr_q [NUM_FIXED];
	logic ack_q;
	logic fault_q;
	logic [MSR_W-1:0] rdata_q;
	logic irq_q;

	event_class_s gen_class [NUM_GEN];
	event_occ_s gen_occ [NUM_GEN];
	logic [NUM_GEN-1:0] gen_hit;
	logic [NUM_GEN-1:0] gen_count;
	logic [NUM_GEN-1:0] gen_wrap;
	logic [NUM_GEN-1:0] gen_wr;
	logic [NUM_GEN-1:0] evsel_wr;
	logic [NUM_FIXED-1:0] fixed_count;
	logic [NUM_FIXED-1:0] fixed_wrap;
	logic [NUM_FIXED-1:0] fixed_wr;
	logic fixed_ctrl_wr;
	logic [NUM_GEN+NUM_FIXED-1:0] ovf_req;
	logic [MSR_W-1:0] rdata_d;
	logic mapped;
	logic [CTR_W:0] gen_next [NUM_GEN];
	logic [CTR_W:0] fixed_next [NUM_FIXED];
	logic [FIXED_FIELD_W-1:0] fixed_field [NUM_FIXED];

	assign gen_class[0] = i_gen_class0;
	assign gen_class[1] = i_gen_class1;
	assign gen_occ[0] = i_gen_occ0;
	assign gen_occ[1] = i_gen_occ1;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Write strobe for one register index
	function automatic logic wr_hit(input msr_req_s req, input logic [IDX_W-1:0] idx);
		return req.wr & (req.idx == idx);
	endfunction

	// Four-bit control field of one fixed counter
	function automatic logic [FIXED_FIELD_W-1:0] ctrl_field(input logic [FIXED_CTRL_W-1:0] ctrl,
		input int f);
		return ctrl[f*FIXED_FIELD_W +: FIXED_FIELD_W];
	endfunction

	// Counter as a full register word, upper bits zero
	function automatic logic [MSR_W-1:0] ctr_word(input logic [CTR_W-1:0] cnt);
		return {{(MSR_W-CTR_W){1'b0}}, cnt};
	endfunction

	// ****************************************************************
	// Register decode
	// ****************************************************************
	assign fixed_ctrl_wr = wr_hit(i_msr_req, REG_FIXED_CTRL);

	always_comb
	begin
		for (int g = 0; g < NUM_GEN; g++)
		begin
			evsel_wr[g] = wr_hit(i_msr_req, REG_EVSEL0 + IDX_W'(g));
			gen_wr[g] = wr_hit(i_msr_req, REG_GEN_CTR0 + IDX_W'(g));
		end
		for (int f = 0; f < NUM_FIXED; f++)
			fixed_wr[f] = wr_hit(i_msr_req, REG_FIXED_CTR0 + IDX_W'(f));
	end

	// ****************************************************************
	// Counter steps and fixed control fields
	// ****************************************************************
	// Carry out of the step is the wrap flag; held in a net so it can be sliced
	always_comb
	begin
		for (int g = 0; g < NUM_GEN; g++)
			gen_next[g] = ctr_step(gen_ctr_q[g]);
		for (int f = 0; f < NUM_FIXED; f++)
		begin
			fixed_next[f] = ctr_step(fixed_ctr_q[f]);
			fixed_field[f] = ctrl_field(fixed_ctrl_q, f);
		end
	end

	// ****************************************************************
	// General counter qualification
	// ****************************************************************
	for (genvar g = 0; g < NUM_GEN; g++)
	begin : gen_qual
		umask_qualify u_qual (
			.i_umask(evsel_q[g][UMASK_LSB +: UMASK_W]),
			.i_class(gen_class[g]),
			.i_occ(gen_occ[g]),
			.o_hit(gen_hit[g])
		);
	end

	always_comb
	begin
		for (int g = 0; g < NUM_GEN; g++)
		begin
			gen_count[g] = gen_hit[g] & evsel_q[g][EVSEL_EN_BIT] &
				priv_match(i_ring0, {evsel_q[g][EVSEL_USR_BIT], evsel_q[g][EVSEL_OS_BIT]});
			gen_wrap[g] = gen_count[g] & ~gen_wr[g] & gen_next[g][CTR_W];
		end
	end

	// ****************************************************************
	// Fixed counter enables
	// ****************************************************************
	always_comb
	begin
		for (int f = 0; f < NUM_FIXED; f++)
		begin
			// Each counter owns one field; the event is hard wired
			fixed_count[f] = i_fixed_event[f] & priv_match(i_ring0,
				fixed_field[f][FIXED_RING0_BIT +: 2]);
			fixed_wrap[f] = fixed_count[f] & ~fixed_wr[f] & fixed_next[f][CTR_W];
		end
	end

	// ****************************************************************
	// Event select registers
	// ****************************************************************
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			for (int g = 0; g < NUM_GEN; g++)
				evsel_q[g] <= EVSEL_RST;
		end
		else if (i_clk_en)
		begin
			for (int g = 0; g < NUM_GEN; g++)
				if (evsel_wr[g])
					evsel_q[g] <= i_msr_req.wdata[EVSEL_W-1:0];
		end
	end

	// ****************************************************************
	// Fixed counter control register
	// ****************************************************************
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			fixed_ctrl_q <= FIXED_CTRL_RST;
		else if (i_clk_en && fixed_ctrl_wr)
			fixed_ctrl_q <= i_msr_req.wdata[FIXED_CTRL_W-1:0];
	end

	// ****************************************************************
	// Counters
	// ****************************************************************
	// Contents are left alone by reset on purpose: software loads them
	always_ff @(posedge i_core_clk)
	begin
		if (i_clk_en)
		begin
			for (int g = 0; g < NUM_GEN; g++)
			begin
				if (gen_wr[g])
					gen_ctr_q[g] <= i_msr_req.wdata[CTR_W-1:0];
				else if (gen_count[g])
					gen_ctr_q[g] <= gen_next[g][CTR_W-1:0];
			end
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_clk_en)
		begin
			for (int f = 0; f < NUM_FIXED; f++)
			begin
				if (fixed_wr[f])
					fixed_ctr_q[f] <= i_msr_req.wdata[CTR_W-1:0];
				else if (fixed_count[f])
					fixed_ctr_q[f] <= fixed_next[f][CTR_W-1:0];
			end
		end
	end

	// ****************************************************************
	// Overflow interrupt request
	// ****************************************************************
	always_comb
	begin
		for (int g = 0; g < NUM_GEN; g++)
			ovf_req[g] = gen_wrap[g] & evsel_q[g][EVSEL_INT_BIT];
		for (int f = 0; f < NUM_FIXED; f++)
			ovf_req[NUM_GEN+f] = fixed_wrap[f] & fixed_field[f][FIXED_INT_BIT];
	end

	// Several wraps in one cycle merge into a single pulse
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			irq_q <= 1'b0;
		else if (i_clk_en)
			irq_q <= |ovf_req;
	end

	assign o_overflow_irq = irq_q;

	// ****************************************************************
	// Read path and response
	// ****************************************************************
	// Unimplemented upper bits always read zero
	always_comb
	begin
		rdata_d = '0;
		mapped = 1'b1;
		unique case (i_msr_req.idx)
			REG_EVSEL0, REG_EVSEL0 + 4'h1:
				rdata_d[EVSEL_W-1:0] = evsel_q[i_msr_req.idx[0]];
			REG_GEN_CTR0, REG_GEN_CTR0 + 4'h1:
				rdata_d = ctr_word(gen_ctr_q[i_msr_req.idx[0]]);
			REG_FIXED_CTRL:
				rdata_d[FIXED_CTRL_W-1:0] = fixed_ctrl_q;
			REG_FIXED_CTR0:
				rdata_d = ctr_word(fixed_ctr_q[0]);
			REG_FIXED_CTR0 + 4'h1:
				rdata_d = ctr_word(fixed_ctr_q[1]);
			REG_FIXED_CTR0 + 4'h2:
				rdata_d = ctr_word(fixed_ctr_q[2]);
			default:
				mapped = 1'b0;
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			ack_q <= 1'b0;
		else if (i_clk_en)
			ack_q <= i_msr_req.wr | i_msr_req.rd;
	end

	// Unmapped index is answered but refused; a write there changes nothing
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			fault_q <= 1'b0;
		else if (i_clk_en)
			fault_q <= (i_msr_req.wr | i_msr_req.rd) & ~mapped;
	end

	// Zero outside a read answer so a stale word never lingers on the port
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			rdata_q <= '0;
		else if (i_clk_en)
			rdata_q <= (i_msr_req.rd && mapped) ? rdata_d : '0;
	end

	assign o_msr_rsp = '{ack: ack_q, fault: fault_q, rdata: rdata_q};

endmodule // perf_event_qualify_fixed_counters

`default_nettype wire

// ---- verification/perf_counters_chk_asserts.sv ----
// Port-level assertion checker for the performance counting block
`default_nettype none
`timescale 1ns/1ps

module perf_counters_chk
	import perf_mon_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	input wire msr_req_s i_msr_req,
	input wire msr_rsp_s o_msr_rsp,
	input wire event_occ_s i_gen_occ0,
	input wire event_occ_s i_gen_occ1,
	input wire logic [NUM_FIXED-1:0] i_fixed_event,
	input wire logic o_overflow_irq
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	property p_ack;
		i_clk_en && (i_msr_req.wr || i_msr_req.rd) |=> o_msr_rsp.ack;
	endproperty
	a_ack: assert property (p_ack) else $error("request not acknowledged");
	property p_ack_cause;
		o_msr_rsp.ack |-> $past(i_clk_en && (i_msr_req.wr || i_msr_req.rd));
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_fault_ack;
		o_msr_rsp.fault |-> o_msr_rsp.ack;
	endproperty
	a_fault_ack: assert property (p_fault_ack) else $error("fault without ack");
	property p_idle_zero;
		!o_msr_rsp.ack |-> o_msr_rsp.rdata == '0;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data outside ack");
	property p_fault_map;
		o_msr_rsp.ack |-> o_msr_rsp.fault == ($past(i_msr_req.idx) > 4'h7);
	endproperty
	a_fault_map: assert property (p_fault_map) else $error("fault on wrong index");
	property p_ctr_width;
		o_msr_rsp.ack && $past(i_msr_req.rd) && $past(i_msr_req.idx) inside {4'h2, 4'h3, 4'h5,
			4'h6, 4'h7} |-> o_msr_rsp.rdata[63:40] == '0;
	endproperty
	a_ctr_width: assert property (p_ctr_width) else $error("counter wider than 40 bits");
	property p_ctrl_width;
		o_msr_rsp.ack && $past(i_msr_req.rd) && $past(i_msr_req.idx) == 4'h4
			|-> o_msr_rsp.rdata[63:12] == '0;
	endproperty
	a_ctrl_width: assert property (p_ctrl_width) else $error("control reads high bits");
	property p_irq_cause;
		o_overflow_irq |-> $past(i_clk_en ? (|i_fixed_event || i_gen_occ0.valid || i_gen_occ1.valid)
			: o_overflow_irq);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without any event");
	property p_reset_quiet;
		$fell(i_rst) |-> !o_overflow_irq && !o_msr_rsp.ack;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
	property p_freeze;
		!i_clk_en |=> $stable(o_msr_rsp) && $stable(o_overflow_irq);
	endproperty
	a_freeze: assert property (p_freeze) else $error("output moved while clock enable low");
endmodule // perf_counters_chk

bind perf_event_qualify_fixed_counters perf_counters_chk u_chk (
	.i_core_clk(i_core_clk),
	.i_rst(i_rst),
	.i_clk_en(i_clk_en),
	.i_msr_req(i_msr_req),
	.o_msr_rsp(o_msr_rsp),
	.i_gen_occ0(i_gen_occ0),
	.i_gen_occ1(i_gen_occ1),
	.i_fixed_event(i_fixed_event),
	.o_overflow_irq(o_overflow_irq)
);

`default_nettype wire

// ---- verification/perf_core_model.sv ----
// Core-side event source feeding the counting block
`default_nettype none
`timescale 1ns/1ps

module perf_core_model
	import perf_mon_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_go,
	output event_occ_s o_occ0,
	output event_occ_s o_occ1,
	output logic [NUM_FIXED-1:0] o_fixed_event,
	output logic o_ring0
);
	// Cache line is in exactly one state; idle fields keep toggling
	function automatic event_occ_s mk(input logic go);
		event_occ_s o;
		o = event_occ_s'($urandom);
		o.line_state = 4'h1 << $urandom_range(3);
		o.valid = go && ($urandom_range(3) != 0);
		return o;
	endfunction

	initial
	begin
		o_occ0 = '0;
		o_occ1 = '0;
		o_fixed_event = '0;
		o_ring0 = 1'b0;
	end

	always @(posedge i_core_clk)
	begin
		o_occ0 <= mk(i_go);
		o_occ1 <= mk(i_go);
		o_fixed_event <= i_go ? 3'($urandom) : 3'h0;
		o_ring0 <= 1'($urandom);
	end
endmodule // perf_core_model

`default_nettype wire

// ---- verification/test_perf_event_qualify_fixed_counters.sv ----
// Self-checking bench for the performance counting block
`default_nettype none
`timescale 1ns/1ps

module test_perf_event_qualify_fixed_counters
	import perf_mon_pkg::*;
;
	logic clk, rst, go, ring0, irq, en;
	msr_req_s req;
	msr_rsp_s rsp;
	event_class_s cls [2];
	event_occ_s occ [2];
	logic [NUM_FIXED-1:0] fev;
	logic [31:0] evsel [2];
	logic [11:0] fctl;
	logic [CTR_W-1:0] expc [5];
	logic [64:0] rsp_q [$];
	logic irq_q [$];
	logic [3:0] ctr_idx [5] = '{4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
	int n_mismatch = 0;
	int compares = 0;

	perf_event_qualify_fixed_counters dut (
		.i_core_clk(clk),
		.i_rst(rst),
		.i_clk_en(en),
		.i_msr_req(req),
		.o_msr_rsp(rsp),
		.i_gen_class0(cls[0]),
		.i_gen_class1(cls[1]),
		.i_gen_occ0(occ[0]),
		.i_gen_occ1(occ[1]),
		.i_ring0(ring0),
		.i_fixed_event(fev),
		.o_overflow_irq(irq)
	);

	perf_core_model u_core (
		.i_core_clk(clk),
		.i_go(go),
		.o_occ0(occ[0]),
		.o_occ1(occ[1]),
		.o_fixed_event(fev),
		.o_ring0(ring0)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ****************************************************************
	// Reference model
	// ****************************************************************
	function automatic logic qual(input logic [7:0] u, input event_class_s c, input event_occ_s o);
		logic h;
		h = o.valid;
		if (c.core_scoped)
			h &= u[7:6] == 2'h3 || (u[7:6] == 2'h1 && o.this_core);
		if (c.upper == UPPER_AGENT)
			h &= u[5] || o.this_agent;
		if (c.upper == UPPER_PREFETCH)
			h &= u[5:4] == 2'h3 || (u[5:4] == 2'h1 && o.hw_prefetch)
				|| (u[5:4] == 2'h0 && !o.hw_prefetch);
		if (c.low == LOW_LINE_STATE)
			h &= |(u[3:0] & o.line_state);
		if (c.low == LOW_SNOOP_RESP)
			h &= !u[2] && (u[3] & o.snoop_hit_modified | u[1] & o.snoop_hit | u[0] & o.snoop_clean);
		if (c.low == LOW_SNOOP_TYPE)
			h &= u[1] & o.snoop_to_invalid | u[0] & o.snoop_to_shared;
		return h;
	endfunction

	function automatic logic inc(input int i);
		if (i < 2)
			return evsel[i][22] && (ring0 ? evsel[i][17] : evsel[i][16])
				&& qual(evsel[i][15:8], cls[i], occ[i]);
		return fev[i-2] && fctl[4*(i-2) + (ring0 ? 0 : 1)];
	endfunction

	task automatic cmp_rsp(input msr_rsp_s got, input logic [64:0] exp);
		compares++;
		if ({got.fault, got.rdata} !== exp)
		begin
			n_mismatch++;
			$display("FAIL %0t response %h expected %h", $time, {got.fault, got.rdata}, exp);
		end
	endtask

	task automatic cmp_irq(input logic ok);
		compares++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("FAIL %0t overflow request count differs", $time);
		end
	endtask

	// Counts follow the inputs sampled at each edge, then results are checked
	always @(posedge clk)
	begin
		logic w;
		if (!rst)
		begin
			w = 1'b0;
			for (int i = 0; i < 5; i++)
				if (en && inc(i))
				begin
					expc[i] = expc[i] + 1'b1;
					w |= expc[i] == '0 && (i < 2 ? evsel[i][20] : fctl[4*i-5]);
				end
			if (rsp.ack)
				cmp_rsp(rsp, rsp_q.size() ? rsp_q.pop_front() : 65'hx);
			if (irq)
				cmp_irq(irq_q.size() != 0);
			if (irq && irq_q.size())
				void'(irq_q.pop_front());
			// A frozen edge holds the request for one more cycle
			if (en ? w : irq)
				irq_q.push_back(1'b1);
		end
	end

	// ****************************************************************
	// Stimulus
	// ****************************************************************
	task automatic acc(input logic w, input logic [3:0] idx, input logic [63:0] d);
		@(posedge clk);
		req <= '{wr: w, rd: !w, idx: idx, wdata: w ? d : 64'h0};
		rsp_q.push_back({idx > 4'h7, w ? 64'h0 : d});
		@(posedge clk);
		req <= '0;
	endtask

	task automatic batch(input logic [3:0] k, input logic ovf);
		event_class_s c;
		for (int i = 0; i < 2; i++)
		begin
			c = event_class_s'($urandom);
			c.upper = upper_qual_e'($urandom_range(2));
			cls[i] <= c;
			evsel[i] = $urandom;
			evsel[i][15:12] = k + 4'(i);
			evsel[i][22] = ovf || k[1:0] != 2'h0;
			evsel[i][20] = ovf;
			acc(1'b1, 4'(i), {32'h0, evsel[i]});
		end
		fctl = 12'($urandom);
		fctl[1:0] = k[1:0];
		fctl[5:4] = k[3:2];
		{fctl[11], fctl[7], fctl[3]} = {3{ovf}};
		acc(1'b1, REG_FIXED_CTRL, {52'h0, fctl});
		for (int i = 0; i < 5; i++)
		begin
			expc[i] = ovf ? 40'hFF_FFFF_FFFF - 40'($urandom_range(3)) : 40'h0;
			acc(1'b1, ctr_idx[i], {24'h0, expc[i]});
		end
		go <= 1'b1;
		// Enable drops at random while events flow, high again before readback
		for (int n = 0; n < 16; n++)
		begin
			@(posedge clk);
			en <= n == 15 || 1'($urandom);
		end
		go <= 1'b0;
		// Event source lags its enable by a cycle
		repeat (3) @(posedge clk);
		for (int i = 0; i < 5; i++)
			acc(1'b0, ctr_idx[i], {24'h0, expc[i]});
		acc(1'b0, REG_EVSEL0, {32'h0, evsel[0]});
		acc(1'b0, REG_FIXED_CTRL, {52'h0, fctl});
	endtask

	task automatic print_verdict;
		$display("Comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		void'($urandom(32'haf69e266));
		rst = 1'b1;
		go = 1'b0;
		en = 1'b1;
		req = '0;
		cls[0] = '0;
		cls[1] = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		acc(1'b0, REG_EVSEL0, 64'h0);
		acc(1'b0, REG_FIXED_CTRL, 64'h0);
		acc(1'b0, 4'h8, 64'h0);
		acc(1'b1, 4'hF, 64'h0000_0000_0000_0ABC);
		for (int k = 0; k < 32; k++)
			batch(4'(k), 1'b0);
		for (int k = 0; k < 8; k++)
			batch(4'(k), 1'b1);
		repeat (4) @(posedge clk);
		cmp_irq(irq_q.size() == 0 && rsp_q.size() == 0);
		print_verdict;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("FAIL %0t watchdog expired", $time);
		print_verdict;
	end
endmodule // test_perf_event_qualify_fixed_counters

`default_nettype wire
